// *** hw/bist_fifo.sv ***
/*
  Small FIFO, valid/ready on both sides.
  Assumes one clock, async active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module bist_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             arst_n,
    // Filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];   // Word storage
    logic [AW-1:0]    wr_ptr;          // Next slot to fill
    logic [AW-1:0]    rd_ptr;          // Next slot to drain
    logic [AW:0]      fill;            // Words held
    wire              push;            // Word accepted
    wire              pop;             // Word delivered

    assign in_ready  = (fill < (AW+1)'(DEPTH));
    assign out_valid = (fill != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // ---------------------------------------------------------------
    // Pointers and count
    // ---------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Storage needs no reset; only filled slots are ever read
    always_ff @(posedge clock)
    begin
        if (push)
            store[wr_ptr] <= in_data;
    end

    // Read data from a register: head word held until popped
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            out_data <= '0;
        else
            out_data <= (pop && fill > (AW+1)'(1)) ?
                        store[(rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1] :
                        (push && (fill == '0 || (pop && fill == (AW+1)'(1)))) ?
                        in_data : (fill != '0 ? store[rd_ptr] : out_data);
    end

endmodule

`default_nettype wire

// *** hw/serial_link_bist.sv ***
/*
  Link self test of a four-port hub, with its registers and pins.
  Assumes decoded register accesses and same-clock receive words.
*/
`timescale 1ns/1ps
`default_nettype none
`include "serial_link_bist_map.svh"

module serial_link_bist #(
    parameter int PORTS    = 4,
    parameter int GP_PINS  = 8,
    parameter int Q_DEPTH  = 4
) (
    // Clock and reset
    input  wire logic                              clock,
    input  wire logic                              arst_n,
    // Local I2C register access
    input  wire serial_link_bist_pkg::reg_req_s    i2c_req,
    output logic                                   i2c_rsp_valid,
    output logic      [7:0]                        i2c_rdata,
    // Control channel register access
    input  wire serial_link_bist_pkg::reg_req_s    chan_req,
    output logic                                   chan_rsp_valid,
    output logic      [7:0]                        chan_rdata,
    // Port page chosen for paged reads
    input  wire logic [1:0]                        read_page,
    // Received words and lock per port
    input  wire serial_link_bist_pkg::rx_word_s [PORTS-1:0] rx_word,
    input  wire logic [PORTS-1:0]                  rx_lock,
    input  wire logic [PORTS-1:0]                  remote_test_active,
    // Back channel write queue
    output logic                                   bc_valid,
    input  wire logic                              bc_ready,
    output serial_link_bist_pkg::bc_write_s        bc_write,
    // Per-port pass pulses
    output logic      [PORTS-1:0]                  pass,
    // General pins
    input  wire logic [GP_PINS-1:0][2:0]           gp_pin_source_select,
    input  wire logic [GP_PINS-1:0]                gp_function_out,
    output logic      [GP_PINS-1:0]                gp_out,
    // Output gating
    input  wire logic                              pattern_gen_enable,
    output logic                                   outputs_enable,
    output logic                                   csi_idle_lp11,
    // Analog monitor
    input  wire logic                              analog_monitor_select,
    output logic                                   analog_monitor_output
);

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    logic [7:0]                      selftest_control;  // Control reg
    logic [1:0]                      pattern_clock_select; // Latched
    serial_link_bist_pkg::seq_state_e state;            // Sequencer
    serial_link_bist_pkg::seq_state_e next_state;
    logic [1:0]                      port_idx;          // Queue walk
    logic [PORTS-1:0]                lock_meta;         // Sync stage 1
    logic [PORTS-1:0]                lock_sync;         // Sync stage 2
    logic [PORTS-1:0]                act_meta;          // Sync stage 1
    logic [PORTS-1:0]                act_sync;          // Sync stage 2
    logic [PORTS-1:0][7:0]           selftest_error_tally;
    logic [PORTS-1:0]                lock_failed;       // Sticky per run
    logic [PORTS-1:0][6:0]           history;           // Pattern state
    logic [PORTS-1:0]                seeded;            // History valid
    logic [PORTS-1:0]                word_err;          // Mismatch now
    serial_link_bist_pkg::bc_write_s q_in;              // Queue entry
    logic [$bits(serial_link_bist_pkg::bc_write_s)-1:0] q_out;
    logic                            q_ready;           // Queue space

    // ---------------------------------------------------------------
    // Register access decode
    // ---------------------------------------------------------------
    // Local port wins when both write the control register at once
    wire i2c_ctrl_wr  = i2c_req.req && i2c_req.write &&
                        (i2c_req.addr == `ADDR_SELFTEST_CTRL);
    wire chan_ctrl_wr = chan_req.req && chan_req.write &&
                        (chan_req.addr == `ADDR_SELFTEST_CTRL);
    wire [7:0] ctrl_wdata = i2c_ctrl_wr ? i2c_req.wdata : chan_req.wdata;
    wire       ctrl_wr    = i2c_ctrl_wr || chan_ctrl_wr;

    wire       test_enable = selftest_control[`CTRL_ENABLE_BIT];
    wire [1:0] test_output_gate =
        selftest_control[`CTRL_OUT_GATE_LSB +: 2];
    wire       running   = (state == serial_link_bist_pkg::ST_RUN);
    wire       in_test   = (state != serial_link_bist_pkg::ST_IDLE);
    wire       start_now = (state == serial_link_bist_pkg::ST_IDLE) &&
                           test_enable;

    // Paged tally: lock failure overrides the count
    wire [7:0] tally_view = lock_failed[read_page] ? `TALLY_LOCK_FAIL :
                            selftest_error_tally[read_page];
    wire [7:0] status_view =
        8'(act_sync[read_page]) << `STATUS_REMOTE_BIT;

    // Read mux shared by both ports; unmapped offsets read zero
    function automatic logic [7:0] read_reg(input logic [7:0] addr);
        return (addr == `ADDR_SELFTEST_CTRL) ? selftest_control :
               (addr == `ADDR_ERROR_TALLY)   ? tally_view :
               (addr == `ADDR_DEBUG_STATUS)  ? status_view : 8'h00;
    endfunction

    // Registered answer one cycle after the request
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            i2c_rsp_valid  <= 1'b0;
            chan_rsp_valid <= 1'b0;
            i2c_rdata      <= 8'h00;
            chan_rdata     <= 8'h00;
        end
        else
        begin
            i2c_rsp_valid  <= i2c_req.req;
            chan_rsp_valid <= chan_req.req;
            if (i2c_req.req && !i2c_req.write)
                i2c_rdata <= read_reg(i2c_req.addr);
            if (chan_req.req && !chan_req.write)
                chan_rdata <= read_reg(chan_req.addr);
        end
    end

    // Control register write
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            selftest_control <= `CTRL_RESET;
        else if (ctrl_wr)
            selftest_control <= ctrl_wdata;
    end

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    // Walk every port through the queue on start and on stop
    wire last_port = (port_idx == 2'(PORTS-1));
    wire q_push    = (state == serial_link_bist_pkg::ST_START ||
                      state == serial_link_bist_pkg::ST_STOP);

    always_comb
    begin
        next_state = state;
        unique case (state)
            serial_link_bist_pkg::ST_IDLE:
                if (test_enable)
                    next_state = serial_link_bist_pkg::ST_START;
            serial_link_bist_pkg::ST_START:
                // Back-pressure holds the walk until queued
                if (q_ready && last_port)
                    next_state = serial_link_bist_pkg::ST_RUN;
            serial_link_bist_pkg::ST_RUN:
                if (!test_enable)
                    next_state = serial_link_bist_pkg::ST_STOP;
            serial_link_bist_pkg::ST_STOP:
                if (q_ready && last_port)
                    next_state = serial_link_bist_pkg::ST_IDLE;
            default:
                next_state = serial_link_bist_pkg::ST_IDLE;
        endcase
    end

    // State, port walk and clock select latch
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state                <= serial_link_bist_pkg::ST_IDLE;
            port_idx             <= 2'h0;
            pattern_clock_select <= 2'h0;
        end
        else
        begin
            state <= next_state;
            if (q_push && q_ready)
                port_idx <= last_port ? 2'h0 : port_idx + 2'h1;
            if (start_now)
                pattern_clock_select <=
                    selftest_control[`CTRL_CLK_SEL_LSB +: 2];
        end
    end

    // Remote test register: enable plus copied clock select
    always_comb
    begin
        q_in      = '0;
        q_in.port = port_idx;
        q_in.addr = `REMOTE_TEST_REG;
        if (state == serial_link_bist_pkg::ST_START)
        begin
            q_in.data[`REMOTE_TEST_EN_BIT] = 1'b1;
            q_in.data[2:1] = pattern_clock_select;
        end
    end

    // ---------------------------------------------------------------
    // Back channel queue
    // ---------------------------------------------------------------
    bist_fifo #(
        .WIDTH ($bits(serial_link_bist_pkg::bc_write_s)),
        .DEPTH (Q_DEPTH)
    ) u_queue (
        .clock     (clock),
        .arst_n    (arst_n),
        .in_valid  (q_push),
        .in_ready  (q_ready),
        .in_data   (q_in),
        .out_valid (bc_valid),
        .out_ready (bc_ready),
        .out_data  (q_out)
    );

    assign bc_write = serial_link_bist_pkg::bc_write_s'(q_out);

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lock_meta <= '0;
            lock_sync <= '0;
            act_meta  <= '0;
            act_sync  <= '0;
        end
        else
        begin
            lock_meta <= rx_lock;
            lock_sync <= lock_meta;
            act_meta  <= remote_test_active;
            act_sync  <= act_meta;
        end
    end

    // ---------------------------------------------------------------
    // Per-port pattern check, seven-bit pseudo-random sequence
    // ---------------------------------------------------------------
    // Predict each bit from the two taps; bit 0 arrives first
    function automatic logic [7:0] prbs_check(input logic [6:0] hist,
                                              input logic [7:0] word,
                                              output logic [6:0] nhist);
        logic [7:0] miss;
        logic [6:0] h;
        h    = hist;
        miss = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            miss[i] = (h[6] ^ h[5]) != word[i];
            h       = {h[5:0], word[i]};
        end
        nhist = h;
        return miss;
    endfunction

    for (genvar p = 0; p < PORTS; p++)
    begin : g_port
        logic [6:0] nh;       // History after this word
        logic [7:0] miss;     // Per-bit mismatches

        always_comb
        begin
            nh   = 7'h00;
            miss = prbs_check(history[p], rx_word[p].data, nh);
        end

        // Every word after the seed word is checked
        assign word_err[p] = running && rx_word[p].valid && seeded[p] &&
                             (miss != 8'h00);

        // History, seed, tally and lock failure
        always_ff @(posedge clock or negedge arst_n)
        begin
            if (!arst_n)
            begin
                history[p]              <= 7'h00;
                seeded[p]               <= 1'b0;
                selftest_error_tally[p] <= `TALLY_CLEAR;
                lock_failed[p]          <= 1'b0;
            end
            else if (start_now)
            begin
                seeded[p]               <= 1'b0;
                selftest_error_tally[p] <= `TALLY_CLEAR;
                lock_failed[p]          <= 1'b0;
            end
            else if (running)
            begin
                if (rx_word[p].valid)
                begin
                    history[p] <= nh;
                    seeded[p]  <= 1'b1;
                end
                // Saturate short of the lock failure code
                if (word_err[p] &&
                    selftest_error_tally[p] != `TALLY_MAX_NORMAL)
                    selftest_error_tally[p] <=
                        selftest_error_tally[p] + 8'h01;
                if (!lock_sync[p])
                    lock_failed[p] <= 1'b1;
            end
        end
    end

    // Pass sits high; one low cycle per detected error
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            pass <= '1;
        else
            pass <= ~word_err;
    end

    // ---------------------------------------------------------------
    // General pin routing
    // ---------------------------------------------------------------
    // Select 1pp: pass pp, 01p: lock p, 00x: normal function
    for (genvar g = 0; g < GP_PINS; g++)
    begin : g_pin
        wire [2:0] sel = gp_pin_source_select[g];
        assign gp_out[g] = sel[2] ? pass[sel[1:0]] :
                           sel[1] ? lock_sync[sel[0]] :
                           gp_function_out[g];
    end

    // ---------------------------------------------------------------
    // Output gating
    // ---------------------------------------------------------------
    // Ungated outside a test; unlisted gate codes mean off
    assign outputs_enable = !in_test ||
                            (test_output_gate == `OUT_GATE_ON);
    assign csi_idle_lp11  = in_test && outputs_enable &&
                            !pattern_gen_enable;
    // Monitor path never passes through the test gate
    assign analog_monitor_output = analog_monitor_select;

endmodule

`default_nettype wire

// *** hw/serial_link_bist_map.svh ***
/*
  Offsets, fields and codes of the link self test.
  Assumes inclusion by bare name.
*/
//
// Contract
// - Control value 0x01 starts test, zero stops
// - Start sends back channel writes entering test
// - Every port checks every word after its seed word against pattern
// - Separate error tally per port, paged read
// - Lock failure reads 0xff, data errors cap 0xfe
// - Pass output pulses low per data error
// - Pass selectable as general pin source
// - Status bit shows remote entered test mode
// - Output gate field: 00 off, 10 on
// - Enabled outputs idle LP11 unless generator runs
// - Clock select copied to remote register bits 2:1
// - Clock select sampled only at test start
// - Analog monitor output stays usable during test
// - Registers reachable from local and channel ports
`ifndef SERIAL_LINK_BIST_MAP_SVH
`define SERIAL_LINK_BIST_MAP_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define ADDR_ERROR_TALLY     8'h57
`define ADDR_SELFTEST_CTRL   8'hb3
`define ADDR_DEBUG_STATUS    8'hd0

// ---------------------------------------------------------------
// Fields and values
// ---------------------------------------------------------------
`define CTRL_RESET           8'h00
`define CTRL_ENABLE_BIT      0
`define CTRL_CLK_SEL_LSB     1
`define CTRL_OUT_GATE_LSB    6
`define OUT_GATE_ON          2'b10
`define STATUS_REMOTE_BIT    5
`define TALLY_LOCK_FAIL      8'hff
`define TALLY_MAX_NORMAL     8'hfe
`define TALLY_CLEAR          8'h00

// ---------------------------------------------------------------
// Remote serializer test register
// ---------------------------------------------------------------
`define REMOTE_TEST_REG      8'h14
`define REMOTE_TEST_EN_BIT   0

`endif

// *** hw/serial_link_bist_pkg.sv ***
/*
  Types of the link self test.
  Assumes nothing.
*/
package serial_link_bist_pkg;

    // One received word from a deserializer port
    typedef struct packed {
        logic       valid;   // Word present this cycle
        logic [7:0] data;    // Bit 0 received first
    } rx_word_s;

    // One register access from a control port
    typedef struct packed {
        logic       req;     // Access this cycle
        logic       write;   // High for write
        logic [7:0] addr;    // Register offset
        logic [7:0] wdata;   // Write data
    } reg_req_s;

    // One write for the back channel to a remote serializer
    typedef struct packed {
        logic [1:0] port;    // Receive port of the remote
        logic [7:0] addr;    // Remote register offset
        logic [7:0] data;    // Remote register value
    } bc_write_s;

    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_START = 4'b0010,
        ST_RUN   = 4'b0100,
        ST_STOP  = 4'b1000
    } seq_state_e;

endpackage

// *** verification/remote_serializer_model.sv ***
/* Remote serializer: takes writes, streams pattern words.
   Assumes the block's clock; slow halves write rate. */
`timescale 1ns/1ps
`default_nettype none
module remote_serializer_model (
    // Clock, reset and test knobs
    input wire logic                             clock,
    input wire logic                             arst_n,
    input wire logic                             slow,
    input wire logic                             inject,
    // Back channel and link side
    input wire logic                             bc_valid,
    output logic                                 bc_ready,
    input wire serial_link_bist_pkg::bc_write_s  bc_write,
    output serial_link_bist_pkg::rx_word_s [3:0] rx_word,
    output logic [3:0]                           active
);
    logic [6:0] lfsr [4];  // Pattern state per port
    logic [6:0] st;        // Working copy
    logic [7:0] w;         // Next word, bit 0 first
    // Remote test register write enters or leaves test mode
    always @(posedge clock or negedge arst_n)
        if (!arst_n)
            active <= 4'h0;
        else if (bc_valid && bc_ready && bc_write.addr == 8'h14)
            active[bc_write.port] <= bc_write.data[0];
    // Words change off the sampling edge of the block
    always @(negedge clock or negedge arst_n)
        if (!arst_n)
        begin
            bc_ready <= 1'b0;
            rx_word <= '0;
            for (int p = 0; p < 4; p++) lfsr[p] <= 7'h01;
        end
        else
        begin
            bc_ready <= slow ? !bc_ready : 1'b1;
            for (int p = 0; p < 4; p++)
            begin
                st = lfsr[p];
                for (int i = 0; i < 8; i++)
                begin
                    w[i] = st[6] ^ st[5];
                    st = {st[5:0], w[i]};
                end
                // Unbroken stream; idle line toggles
                rx_word[p].valid <= active[p];
                rx_word[p].data <= active[p] ?
                    w ^ {7'h00, inject && p == 0} : ~rx_word[p].data;
                if (active[p]) lfsr[p] <= st;
            end
        end
endmodule
`default_nettype wire

// *** verification/serial_link_bist_monitor.sv ***
/* Port checker of the link self test.
   Assumes binding onto the block. */
`timescale 1ns/1ps
`default_nettype none
module serial_link_bist_monitor #(
    parameter int PORTS   = 4,
    parameter int GP_PINS = 8
) (
    // Clock, reset and local register port
    input wire logic                            clock,
    input wire logic                            arst_n,
    input wire serial_link_bist_pkg::reg_req_s  i2c_req,
    input wire logic                            i2c_rsp_valid,
    input wire logic [7:0]                      i2c_rdata,
    // Back channel queue head
    input wire logic                            bc_valid,
    input wire logic                            bc_ready,
    input wire serial_link_bist_pkg::bc_write_s bc_write,
    // Pass pulses, pins and outputs
    input wire logic [PORTS-1:0]                pass,
    input wire logic [GP_PINS-1:0][2:0]         gp_pin_source_select,
    input wire logic [GP_PINS-1:0]              gp_out,
    input wire logic                            pattern_gen_enable,
    input wire logic                            outputs_enable,
    input wire logic                            csi_idle_lp11,
    input wire logic                            analog_monitor_select,
    input wire logic                            analog_monitor_output
);
    // One domain: one clocking, one disable
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    property p_rsp; i2c_req.req |=> i2c_rsp_valid; endproperty
    a_rsp: assert property (p_rsp) else $error("no answer");
    property p_st; i2c_req.req && !i2c_req.write && i2c_req.addr == 8'hd0
        |=> (i2c_rdata & 8'hdf) == 8'h00; endproperty
    a_st: assert property (p_st) else $error("status junk");
    property p_bca; bc_valid |-> bc_write.addr == 8'h14; endproperty
    a_bca: assert property (p_bca) else $error("remote addr");
    // A stalled head must not move or vanish
    property p_hold; bc_valid && !bc_ready |=> bc_valid && $stable(bc_write);
    endproperty
    a_hold: assert property (p_hold) else $error("head lost");
    property p_pass; !pass[0] |-> ##[1:400] pass[0]; endproperty
    a_pass: assert property (p_pass) else $error("long pass low");
    property p_gp; gp_pin_source_select[0] == 3'b100 |-> gp_out[0] == pass[0];
    endproperty
    a_gp: assert property (p_gp) else $error("pin source");
    property p_am; analog_monitor_output == analog_monitor_select; endproperty
    a_am: assert property (p_am) else $error("monitor out");
    property p_lp; csi_idle_lp11 |-> outputs_enable && !pattern_gen_enable;
    endproperty
    a_lp: assert property (p_lp) else $error("idle state");
    c_pop: cover property (bc_valid && bc_ready);
    c_err: cover property ($fell(pass[0]));
    c_lp: cover property (csi_idle_lp11);
endmodule
bind serial_link_bist serial_link_bist_monitor
    #(.PORTS(PORTS), .GP_PINS(GP_PINS)) u_mon (.*);
`default_nettype wire

// *** verification/serial_link_bist_tb.sv ***
/* Bench of the link self test.
   Assumes the block, checker and remote model. */
`timescale 1ns/1ps
`default_nettype none
module serial_link_bist_tb;
    logic clock = 0, arst_n = 0, slow = 1, inject = 0, pgen = 0, amon = 0;
    serial_link_bist_pkg::reg_req_s i2c_req = '0, chan_req = '0;
    serial_link_bist_pkg::rx_word_s [3:0] rx;
    serial_link_bist_pkg::bc_write_s bcw, log[$];
    logic [1:0] page = 2'h0;
    logic [3:0] lock = 4'hf, act, pass;
    logic [7:0][2:0] sel = {18'h0, 3'b010, 3'b100};  // Pin0 pass, pin1 lock
    logic [7:0] rd_i, rd_c, gp, d;
    logic rsp_i, rsp_c, bc_valid, bc_ready, oe, lp11, amon_o;
    int n_errors = 0, compares = 0, cyc = 0;
    serial_link_bist DUT (.clock(clock), .arst_n(arst_n), .i2c_req(i2c_req),
        .i2c_rsp_valid(rsp_i), .i2c_rdata(rd_i), .chan_req(chan_req),
        .chan_rsp_valid(rsp_c), .chan_rdata(rd_c), .read_page(page),
        .rx_word(rx), .rx_lock(lock), .remote_test_active(act),
        .bc_valid(bc_valid), .bc_ready(bc_ready), .bc_write(bcw), .pass(pass),
        .gp_pin_source_select(sel), .gp_function_out(8'h00), .gp_out(gp),
        .pattern_gen_enable(pgen), .outputs_enable(oe), .csi_idle_lp11(lp11),
        .analog_monitor_select(amon), .analog_monitor_output(amon_o));
    remote_serializer_model remote (.clock(clock), .arst_n(arst_n),
        .slow(slow), .inject(inject), .bc_valid(bc_valid),
        .bc_ready(bc_ready), .bc_write(bcw), .rx_word(rx), .active(act));
    always #2.5 clock = ~clock;
    // Log every back channel write
    always @(posedge clock) if (bc_valid && bc_ready) log.push_back(bcw);
    task automatic chk(input string n, input logic [7:0] e, g);
        compares++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // One read; answer stands one cycle later
    task automatic rd(input bit ch, input logic [7:0] a, input logic [1:0] p);
        @(negedge clock);
        page <= p;
        if (ch) chan_req <= '{1'b1, 1'b0, a, 8'h00};
        else i2c_req <= '{1'b1, 1'b0, a, 8'h00};
        @(negedge clock);
        chan_req.req <= 1'b0;
        i2c_req.req <= 1'b0;
        d = ch ? rd_c : rd_i;
        chk("answer", 8'h01, {7'h0, ch ? rsp_c : rsp_i});
    endtask
    task automatic wr(input logic [7:0] v);
        @(negedge clock);
        i2c_req <= '{1'b1, 1'b1, 8'hb3, v};
        @(negedge clock);
        i2c_req.req <= 1'b0;
    endtask
    // Four remote writes: count, order, contents
    task automatic remote4(input int f, input logic [7:0] v);
        repeat (80) if (log.size() < f + 4) @(negedge clock);
        chk("writes", 8'(f + 4), 8'(log.size()));
        for (int i = f; i < f + 4 && i < log.size(); i++)
        begin
            chk("port", 8'(i - f), {6'h0, log[i].port});
            chk("data", v, log[i].data);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            n_errors++;
            complete_run();
        end
    end
    initial
    begin
        repeat (3) @(negedge clock);
        arst_n <= 1'b1;
        rd(0, 8'hb3, 2'h0);
        chk("control", 8'h00, d);
        rd(1, 8'h80, 2'h0);
        chk("unmapped", 8'h00, d);
        wr(8'h83);  // Clock code 01, outputs on; code 11 avoided
        remote4(0, 8'h03);
        wr(8'h85);
        amon <= 1'b1;
        repeat (20) @(negedge clock);
        chk("late writes", 8'h04, 8'(log.size()));
        rd(1, 8'hd0, 2'h0);
        chk("remote active", 8'h20, d);
        chk("gate", 8'h03, {6'h0, oe, lp11});
        chk("lock pin", 8'h01, {7'h0, gp[1]});
        pgen <= 1'b1;
        rd(0, 8'h57, 2'h0);
        chk("clean", 8'h00, d);
        chk("video", 8'h02, {6'h0, oe, lp11});
        $display("start test done");
        inject <= 1'b1;
        @(negedge clock);
        inject <= 1'b0;
        rd(0, 8'h57, 2'h0);
        chk("counts", 8'h01, {7'h0, d > 8'h00 && d < 8'h09});
        inject <= 1'b1;
        repeat (300) @(negedge clock);
        inject <= 1'b0;
        rd(0, 8'h57, 2'h0);
        chk("cap", 8'hfe, d);
        rd(0, 8'h57, 2'h1);
        chk("other port", 8'h00, d);
        lock[2] <= 1'b0;
        repeat (5) @(negedge clock);
        rd(0, 8'h57, 2'h2);
        chk("lock lost", 8'hff, d);
        lock[2] <= 1'b1;
        $display("error test done");
        wr(8'h00);
        remote4(4, 8'h00);
        wr(8'h01);
        remote4(8, 8'h01);
        chk("gated", 8'h00, {7'h0, oe});
        rd(0, 8'h57, 2'h0);
        chk("cleared", 8'h00, d);
        $display("restart test done");
        complete_run();
    end
endmodule
`default_nettype wire
